// [hw/fan_cfg_pkg.sv]
// Purpose: Shared constants and types for the fan monitor configuration bank
// Assumes: Byte-wide registers reached through the serial management port engine
// Notes: Offsets are the byte addresses seen by the host
package fan_cfg_pkg;

  // Register offsets
  localparam logic [7:0] CONFIG_FOUR_PIN_AND_INPUT_ADDR = 8'h7d;
  localparam logic [7:0] FACTORY_TEST_ONE_ADDR = 8'h7e;
  localparam logic [7:0] FACTORY_TEST_TWO_ADDR = 8'h7f;

  // Reset values
  localparam logic [7:0] CONFIG_FOUR_RESET = 8'h00;
  localparam logic [7:0] FACTORY_TEST_RESET = 8'h00;

  // Field positions inside configuration register four
  localparam int PIN_ROLE_LSB = 0;
  localparam int THRESHOLD_LSB = 2;
  localparam int BYPASS_BIT = 5;

  // Bits that hold storage; the others read as zero
  localparam logic [7:0] CONFIG_FOUR_WRITE_MASK = 8'h2f;

  // Pin role encodings
  localparam logic [1:0] ROLE_FAN_TACH = 2'h0;
  localparam logic [1:0] ROLE_THERMAL = 2'h1;
  localparam logic [1:0] ROLE_SMB_ALERT = 2'h2;
  localparam logic [1:0] ROLE_GPIO = 2'h3;

  // Two-wire threshold encodings: 20, 40, 80, 130 mV
  localparam logic [1:0] THRESH_20MV = 2'h0;
  localparam logic [1:0] THRESH_40MV = 2'h1;
  localparam logic [1:0] THRESH_80MV = 2'h2;
  localparam logic [1:0] THRESH_130MV = 2'h3;

  // Frequency range bit values
  localparam logic PWM_HIGH_FREQ = 1'b0;
  localparam logic PWM_LOW_FREQ = 1'b1;

  // Layout of configuration register four
  typedef struct packed {
    logic [1:0] unusedHigh;  // Bits 7:6
    logic supplyAttenuatorBypass;  // Bit 5
    logic unusedFour;  // Bit 4
    logic [1:0] twoWireThresholdSelect;  // Bits 3:2
    logic [1:0] pinRole;  // Bits 1:0
  } config_four_t;

  // One-hot view of the multi-use pin role
  typedef struct packed {
    logic gpioEnable;
    logic smbAlertOut;
    logic thermalAlarmPin;
    logic fanTachInputFour;
  } pin_role_t;

  localparam pin_role_t PIN_ROLE_RESET = 4'h1;

endpackage

// [hw/fan_monitor_config_four_regs.sv]
// Purpose: Configuration register four and the two factory test registers
// Assumes: Serial port engine on ref_clk gives one-cycle read and write strobes
// Notes: Lock and frequency range come from sibling config registers
//
// Notes on behaviour
// - Bits 1:0 choose multi-use pin role
// - Bits 3:2 pick threshold, low-frequency mode only
// - Bit 5 bypasses processor supply channel attenuator
// - After lock, register four ignores all writes
// - Frequency range bit: zero high, one low
`timescale 1ns/1ps
module fan_monitor_config_four_regs
  import fan_cfg_pkg::*;
(
  input wire logic ref_clk,  // System clock, 125 MHz
  input wire logic sys_rst,  // Async reset, active high
  input wire logic [7:0] regAddr,  // Register offset from port engine
  input wire logic [7:0] regWdata,  // Write data
  input wire logic regWrite,  // Write strobe, one cycle
  input wire logic regRead,  // Read strobe, one cycle
  input wire logic globalLock,  // Lock bit of config register one
  input wire logic pwmFrequencyRange,  // Frequency range bit of config five
  output logic [7:0] regRdata,  // Read data, valid with regRvalid
  output logic regRvalid,  // Read answer pulse
  output logic regHit,  // Answer addressed this bank
  output logic writeRefused,  // Pulse: locked write was dropped
  output pin_role_t pinRole,  // One-hot pin role
  output logic [1:0] twoWireThresholdSelect,  // Threshold in force
  output logic thresholdActive,  // Threshold applies (low freq mode)
  output logic supplyAttenuatorBypass  // Attenuator bypassed
);

  config_four_t cfgFour;  // Stored configuration register four
  logic lockSeen;  // Sticky copy of the lock bit
  logic locked;  // Writes are blocked
  logic cfgWriteHit;  // Write aimed at register four

  // Every check below runs on the one clock and rests while reset is high;
  // checks that look back in time therefore start fresh after each reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Read decode used by the answer path; bit 8 tells whether this bank
  // owns the offset, so the port engine can route a miss elsewhere
  function automatic logic [8:0] readMux(input logic [7:0] addr, input config_four_t cfg);
    logic [8:0] result;  // Hit flag above the data byte
    result = 9'h000;  // Miss unless an offset below matches
    // Register four shows only its stored fields; test registers are zero
    case (addr)
      CONFIG_FOUR_PIN_AND_INPUT_ADDR: result = {1'b1, cfg & CONFIG_FOUR_WRITE_MASK};
      FACTORY_TEST_ONE_ADDR: result = {1'b1, FACTORY_TEST_RESET};
      FACTORY_TEST_TWO_ADDR: result = {1'b1, FACTORY_TEST_RESET};
      default: result = 9'h000;
    endcase
    return result;
  endfunction

  // Writes are blocked by the live lock bit or by its sticky copy
  assign locked = globalLock | lockSeen;
  // Only a strobe aimed at register four may change the store
  assign cfgWriteHit = regWrite && (regAddr == CONFIG_FOUR_PIN_AND_INPUT_ADDR);

  // Lock stays once seen; only reset frees it, so a later clear of the
  // sibling bit cannot reopen the register. The live bit is also ORed in
  // above, so a write in the very cycle the lock rises is still refused
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockSeen <= 1'b0;  // Unlocked after reset
    end else if (globalLock) begin
      lockSeen <= 1'b1;
    end
  end

  // The lock never lifts again short of a reset
  a_lock_sticky: assert property (
    locked |=> locked)
    else $error("lock lifted without reset");

  // Register four storage; unused bits never take a one, so reads need
  // no extra masking downstream of the store
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgFour <= CONFIG_FOUR_RESET;  // Tachometer role, smallest threshold, attenuator in
    end else if (cfgWriteHit && !locked) begin
      cfgFour <= regWdata & CONFIG_FOUR_WRITE_MASK;
    end
  end

  // Once locked, the store must hold across the next two edges
  a_locked_write_ignored: assert property (
    locked |=> $stable(cfgFour) [*2])
    else $error("register four changed while locked");

  // Writes to the test registers or to unmapped offsets leave it alone
  a_test_write_harmless: assert property (
    regWrite && regAddr != CONFIG_FOUR_PIN_AND_INPUT_ADDR |=> $stable(cfgFour))
    else $error("register four changed by a write elsewhere");

  // Bits 4, 6 and 7 never hold a one, whatever the host wrote
  a_unused_never_stored: assert property (
    (cfgFour & ~CONFIG_FOUR_WRITE_MASK) == 8'h00)
    else $error("unused bit of register four stored");

  // Report dropped writes so the port engine can flag them; a pulse rather
  // than a sticky flag, since the engine decides what the host gets to see
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      writeRefused <= 1'b0;  // Nothing refused yet
    end else begin
      writeRefused <= cfgWriteHit && locked;
    end
  end

  // A locked write raises the flag and leaves the store untouched
  a_lock_refusal_flag: assert property (
    cfgWriteHit && locked |=> writeRefused && $stable(cfgFour))
    else $error("locked write not refused");

  // The flag is a one-cycle pulse that only a locked write raises
  a_refusal_pulse: assert property (
    !(cfgWriteHit && locked) |=> !writeRefused)
    else $error("refusal flag without a locked write");

  // Read answer one cycle after the strobe; test registers are constant
  // zero and writes to them are simply not decoded. A read and a write in
  // the same cycle return the value from before the write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
      regRvalid <= 1'b0;
      regHit <= 1'b0;
    end else begin
      regRvalid <= regRead;  // Exactly one cycle after the strobe
      if (regRead) begin
        {regHit, regRdata} <= readMux(regAddr, cfgFour);
      end else begin
        // Rest at zero between answers so a stray sample reads nothing
        regHit <= 1'b0;
        regRdata <= 8'h00;
      end
    end
  end

  // Test registers answer as hits with all bits clear
  a_test_regs_zero: assert property (
    regRead && (regAddr == FACTORY_TEST_ONE_ADDR || regAddr == FACTORY_TEST_TWO_ADDR)
    |=> regRvalid && regHit && regRdata == 8'h00)
    else $error("test register read not zero");

  // Register four never shows a one in its unused bits
  a_unused_zero: assert property (
    regRead && regAddr == CONFIG_FOUR_PIN_AND_INPUT_ADDR |=> (regRdata & 8'hd0) == 8'h00)
    else $error("unused bits read nonzero");

  // Threshold only matters when the fan drive runs in low frequency mode;
  // the field is passed on regardless and thresholdActive tells the
  // measurement engine whether to use it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      twoWireThresholdSelect <= THRESH_20MV;  // Smallest threshold after reset
      thresholdActive <= 1'b0;  // High frequency drive after reset
    end else begin
      twoWireThresholdSelect <= cfgFour.twoWireThresholdSelect;
      thresholdActive <= (pwmFrequencyRange == PWM_LOW_FREQ);
    end
  end

  // Threshold field reaches the output two edges after the write
  a_threshold_follows: assert property (
    cfgWriteHit && !locked |=> ##1 twoWireThresholdSelect == $past(regWdata[3:2], 2))
    else $error("threshold does not follow written field");

  // The gate tracks the frequency range bit with one cycle of lag, both ways
  a_mode_gate: assert property (
    1'b1 |=> thresholdActive == ($past(pwmFrequencyRange) == PWM_LOW_FREQ))
    else $error("threshold gate does not follow frequency range");

  // Attenuator bypass drives the supply channel scaling; the measurement
  // engine rescales its readings whenever this bit is set
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supplyAttenuatorBypass <= 1'b0;  // Attenuator in after reset
    end else begin
      supplyAttenuatorBypass <= cfgFour.supplyAttenuatorBypass;
    end
  end

  // Bypass bit reaches the output two edges after the write
  a_bypass_follows: assert property (
    cfgWriteHit && !locked |=> ##1 supplyAttenuatorBypass == $past(regWdata[5], 2))
    else $error("bypass does not follow written bit");

  // Pin role decoder; the one-hot view costs a cycle but keeps every
  // role enable on a flop of its own
  pin_role_decode roleDecode (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .roleField(cfgFour.pinRole),
    .pinRole(pinRole)
  );

  // Written role shows up two edges later as a single active enable
  a_role_follows_write: assert property (
    cfgWriteHit && !locked |=> ##1 pinRole == pin_role_t'(4'h1 << $past(regWdata[1:0], 2)))
    else $error("pin role does not follow written field");

  // Exactly one role is active at any time
  a_role_one_hot: assert property ($onehot(pinRole))
    else $error("pin role not one-hot");

  // Unlocked write that selects the general-purpose role
  c_unlocked_write: cover property (cfgWriteHit && !locked ##2 pinRole.gpioEnable);
  // Unlocked write that selects the thermal alarm role
  c_thermal_role: cover property (
    cfgWriteHit && !locked && regWdata[1:0] == ROLE_THERMAL ##2 pinRole.thermalAlarmPin);
  // Write dropped under lock
  c_locked_write: cover property (cfgWriteHit && locked ##1 writeRefused);
  // Largest threshold in force while low frequency drive is selected
  c_low_freq_threshold: cover property (thresholdActive && twoWireThresholdSelect == THRESH_130MV);
  // Read of the second test register
  c_test_read: cover property (regRead && regAddr == FACTORY_TEST_TWO_ADDR);

endmodule

// [hw/pin_role_decode.sv]
// Purpose: Registered one-hot decode of the multi-use pin role field
// Assumes: Field comes from a flop on the same clock
// Notes: One cycle of latency after the field changes
`timescale 1ns/1ps
module pin_role_decode
  import fan_cfg_pkg::*;
(
  input wire logic ref_clk,  // System clock
  input wire logic sys_rst,  // Async reset, active high
  input wire logic [1:0] roleField,  // Pin role field
  output pin_role_t pinRole  // One-hot role, registered
);

  // Decode the field; tachometer input is the reset role
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinRole <= PIN_ROLE_RESET;
    end else begin
      pinRole.fanTachInputFour <= (roleField == ROLE_FAN_TACH);
      pinRole.thermalAlarmPin <= (roleField == ROLE_THERMAL);
      pinRole.smbAlertOut <= (roleField == ROLE_SMB_ALERT);
      pinRole.gpioEnable <= (roleField == ROLE_GPIO);
    end
  end

endmodule

// [sim/fan_monitor_config_four_regs_test.sv]
// Purpose: Self-checking bench for the configuration register four bank
// Assumes: Strobes are driven on the falling edge and answers are sampled one edge later
// Notes: The lock is sticky until reset, so the lock test runs last
`timescale 1ns/1ps
module fan_monitor_config_four_regs_test
  import fan_cfg_pkg::*;
;
  logic ref_clk = 1'b0;  // System clock, 8 ns period
  logic sys_rst = 1'b1;  // Reset, active high
  logic [7:0] regAddr = 8'h00;  // Register offset
  logic [7:0] regWdata = 8'h00;  // Write data
  logic regWrite = 1'b0;  // Write strobe
  logic regRead = 1'b0;  // Read strobe
  logic globalLock = 1'b0;  // Lock bit from the sibling register
  logic pwmFrequencyRange = 1'b0;  // Frequency range bit
  logic [7:0] regRdata;  // Read data
  logic regRvalid;  // Read answer
  logic regHit;  // Answer hit this bank
  logic writeRefused;  // Locked write dropped
  pin_role_t pinRole;  // One-hot pin role
  logic [1:0] twoWireThresholdSelect;  // Threshold in force
  logic thresholdActive;  // Threshold applies
  logic supplyAttenuatorBypass;  // Attenuator bypassed
  int mismatches = 0;  // Failed comparisons
  int num_checks = 0;  // All comparisons
  logic refused;  // Refusal flag seen after a write
  logic [9:0] answer;  // Valid, hit and data seen by a read

  fan_monitor_config_four_regs DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .globalLock(globalLock),
    .pwmFrequencyRange(pwmFrequencyRange), .regRdata(regRdata), .regRvalid(regRvalid),
    .regHit(regHit), .writeRefused(writeRefused), .pinRole(pinRole),
    .twoWireThresholdSelect(twoWireThresholdSelect), .thresholdActive(thresholdActive),
    .supplyAttenuatorBypass(supplyAttenuatorBypass)
  );

  // Free-running clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  // Compare and count; four-state equality so unknowns never match
  task automatic check(input logic [9:0] s, input logic [9:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask

  // One-cycle write; waits one more cycle so registered decodes settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    refused = writeRefused;
    @(negedge ref_clk);
  endtask

  // One-cycle read; the answer stands only in the following cycle
  task automatic rd(input logic [7:0] a);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    answer = {regRvalid, regHit, regRdata};
  endtask

  // Counts, then the verdict
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    check({6'h0, pinRole}, 10'h001);
    check({7'h0, twoWireThresholdSelect, supplyAttenuatorBypass}, 10'h000);
    for (int i = 0; i < 3; i++) begin
      rd(CONFIG_FOUR_PIN_AND_INPUT_ADDR + 8'(i));
      check(answer, 10'h300);
    end
    $display("test reset done");
    // Every pin role, and no refusal while unlocked
    for (int i = 0; i < 4; i++) begin
      wr(CONFIG_FOUR_PIN_AND_INPUT_ADDR, 8'(i));
      check({6'h0, pinRole}, 10'(4'h1 << i));
      check({9'h0, refused}, 10'h000);
    end
    $display("test roles done");
    // Every threshold code together with the bypass bit
    for (int i = 0; i < 4; i++) begin
      wr(CONFIG_FOUR_PIN_AND_INPUT_ADDR, 8'h20 | 8'(i << 2));
      check({8'h0, twoWireThresholdSelect}, 10'(i));
      check({9'h0, supplyAttenuatorBypass}, 10'h001);
    end
    wr(CONFIG_FOUR_PIN_AND_INPUT_ADDR, 8'h00);
    check({9'h0, supplyAttenuatorBypass}, 10'h000);
    wr(CONFIG_FOUR_PIN_AND_INPUT_ADDR, 8'hff);
    rd(CONFIG_FOUR_PIN_AND_INPUT_ADDR);
    check(answer, 10'h32f);
    $display("test fields done");
    // Threshold applies only in low frequency mode
    pwmFrequencyRange = PWM_LOW_FREQ;
    repeat (2) @(negedge ref_clk);
    check({9'h0, thresholdActive}, 10'h001);
    pwmFrequencyRange = PWM_HIGH_FREQ;
    repeat (2) @(negedge ref_clk);
    check({9'h0, thresholdActive}, 10'h000);
    $display("test frequency done");
    // Test registers stay zero after writes; unmapped reads miss
    wr(FACTORY_TEST_ONE_ADDR, 8'ha5);
    wr(FACTORY_TEST_TWO_ADDR, 8'h5a);
    rd(FACTORY_TEST_ONE_ADDR);
    check(answer, 10'h300);
    rd(FACTORY_TEST_TWO_ADDR);
    check(answer, 10'h300);
    rd(8'h10);
    check(answer, 10'h200);
    $display("test reserved done");
    // Lock refuses writes, and stays in force after the lock bit drops
    globalLock = 1'b1;
    wr(CONFIG_FOUR_PIN_AND_INPUT_ADDR, 8'h01);
    check({9'h0, refused}, 10'h001);
    globalLock = 1'b0;
    wr(CONFIG_FOUR_PIN_AND_INPUT_ADDR, 8'h00);
    check({9'h0, refused}, 10'h001);
    rd(CONFIG_FOUR_PIN_AND_INPUT_ADDR);
    check(answer, 10'h32f);
    check({6'h0, pinRole}, 10'h008);
    $display("test lock done");
    give_verdict();
  end

  // Watchdog: the whole sequence needs well under 20 us
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
endmodule
